/* File: verilog/spc_defs.svh */
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

// register byte addresses (word aligned)
`define SPC_ADDR_CONTROL     4'h0
`define SPC_ADDR_STATUS      4'h4
`define SPC_ADDR_EVENT       4'h8

// control register field positions
`define SPC_BIT_IRQ_EN       3'd7
`define SPC_BIT_PORT_EN      3'd6
`define SPC_BIT_HALF_DIV     3'd5
`define SPC_BIT_MASTER       3'd4
`define SPC_BIT_CPOL         3'd3
`define SPC_BIT_CPHA         3'd2

// status register field positions
`define SPC_BIT_EOT          2'd0
`define SPC_BIT_MODE_FAULT_FLAG         2'd1
`define SPC_BIT_OVR          2'd2

// upper nibble resets to zero, lower nibble is also loaded with zero
`define SPC_CTRL_UPPER_RST   4'h0
`define SPC_CTRL_LOWER_INIT  4'h0

// divide ratios in cpu clocks per sck period
`define SPC_DIV_4            8'd4
`define SPC_DIV_8            8'd8
`define SPC_DIV_16           8'd16
`define SPC_DIV_32           8'd32
`define SPC_DIV_64           8'd64
`define SPC_DIV_128          8'd128

`endif

/* File: verilog/spc_pkg.sv */
package spc_pkg;
    typedef enum logic [1:0] {
        SPC_BUS_IDLE,
        SPC_BUS_ANSWER
    } spc_bus_state_t;
endpackage

/* File: verilog/spc_rate_sel.sv */
`include "spc_defs.svh"

module spc_rate_sel
    import spc_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       run_in,
    input  wire logic       half_divider_select_in,
    input  wire logic [1:0] rate_bits_in,
    output logic            tick_out
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } spc_rate_state_t;

    spc_rate_state_t st_q;
    spc_rate_state_t st_d;
    logic [7:0]      half_period;

    // ratio encoding {half_divider_select, rate_bits}
    function automatic logic [7:0] ratio_of(input logic [2:0] sel);
        case (sel)
            3'b100:  ratio_of = `SPC_DIV_4;
            3'b000:  ratio_of = `SPC_DIV_8;
            3'b001:  ratio_of = `SPC_DIV_16;
            3'b110:  ratio_of = `SPC_DIV_32;
            3'b010:  ratio_of = `SPC_DIV_64;
            3'b011:  ratio_of = `SPC_DIV_128;
            // codes 101 and 111 are not listed; fall back to slowest
            default: ratio_of = `SPC_DIV_128;
        endcase
    endfunction

    assign half_period = ratio_of({half_divider_select_in, rate_bits_in}) >> 1;

    always_comb begin
        st_d      = st_q;
        st_d.tick = 1'b0;
        if (!run_in) begin
            st_d.cnt = 8'h00;
        end else if (st_q.cnt >= half_period - 8'h01) begin
            st_d.cnt  = 8'h00;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick_out = st_q.tick;
endmodule // spc_rate_sel

/* File: verilog/spc_control.sv */
// Notes on behaviour
// - irq enable high raises interrupt on end-of-transfer, mode-fault or overrun flags.
// - port enable connects serial pins when set; cleared by reset.
// - master with slave select sampled low clears port enable and master select.
// - half divider bit zero adds divide-by-two; cleared by reset; ignored as slave.
// - master select makes sck an output and swaps miso and mosi roles.
// - cpol sets sck idle level in both master and slave modes.
// - cpha zero captures on first sck edge, one on second edge.
// - slave uses the same cpol and cpha as its master.
// - half divider and rate bits pick master sck rate; ignored as slave.
// - master sck is cpu clock divided by 4, 8, 16, 32, 64 or 128.
// - upper control nibble resets to zero; lower nibble undefined. This design loads the lower nibble with zero.
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`include "spc_defs.svh"

module spc_control
    import spc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // events from the shifter
    input  wire logic        end_of_transfer_in,
    input  wire logic        overrun_in,
    input  wire logic        xfer_busy_in,
    // serial pins
    input  wire logic        ss_n_in,
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe_out,
    output logic             mosi_oe_out,
    output logic             miso_oe_out,
    output logic             pins_to_port_out,
    output logic             cpha_out,
    output logic             cpol_out,
    output logic             master_out,
    output logic             sample_edge_out,
    output logic             irq_out
);
    typedef struct packed {
        spc_bus_state_t bus;
        logic [31:0]    rdata;
        logic [7:0]     ctrl;
        logic           end_of_transfer_flag;
        logic           mode_fault_flag;
        logic           overrun_flag;
        logic [1:0]     ss_sync;
        logic [1:0]     sck_sync;
        logic           sck_prev;
        logic           sck_lvl;
        logic           edge_odd;
        logic           sample;
        logic           irq;
        logic           sck_oe;
        logic           mosi_oe;
        logic           miso_oe;
        logic           pins;
        logic           cpha;
        logic           cpol;
        logic           master;
        logic           sck_drv;
        logic           waitreq;
    } spc_ctrl_state_t;

    spc_ctrl_state_t st_q;
    spc_ctrl_state_t st_d;
    logic            tick;
    logic            run;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    assign run = st_q.ctrl[`SPC_BIT_MASTER] && st_q.ctrl[`SPC_BIT_PORT_EN] && xfer_busy_in;

    spc_rate_sel u_rate (
        .clk_in                 (clk_in),
        .rst_in                 (rst_in),
        .run_in                 (run),
        .half_divider_select_in (st_q.ctrl[`SPC_BIT_HALF_DIV]),
        .rate_bits_in           (st_q.ctrl[1:0]),
        .tick_out               (tick)
    );

    always_comb begin
        logic master_now;
        logic cpol_now;
        logic sck_edge;
        master_now = 1'b0;
        cpol_now   = 1'b0;
        sck_edge   = 1'b0;
        st_d        = st_q;
        st_d.sample = 1'b0;

        // pin synchronisers
        st_d.ss_sync  = {st_q.ss_sync[0], ss_n_in};
        st_d.sck_sync = {st_q.sck_sync[0], sck_in};
        st_d.sck_prev = st_q.sck_sync[1];

        // hardware events: set wins over software clear
        if (end_of_transfer_in) begin
            st_d.end_of_transfer_flag = 1'b1;
        end
        if (overrun_in) begin
            st_d.overrun_flag = 1'b1;
        end

        // bus slave: one wait cycle, answer on the second edge
        case (st_q.bus)
            SPC_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    st_d.bus   = SPC_BUS_ANSWER;
                    st_d.rdata = 32'h0000_0000;
                    // registered on entry so it stands through the answer cycle
                    if (avs_read) begin
                        if (hit(avs_address, `SPC_ADDR_CONTROL)) begin
                            st_d.rdata = {24'h00_0000, st_q.ctrl};
                        end else if (hit(avs_address, `SPC_ADDR_STATUS)) begin
                            st_d.rdata = {29'h0000_0000, st_q.overrun_flag,
                                          st_q.mode_fault_flag, st_q.end_of_transfer_flag};
                        end else if (hit(avs_address, `SPC_ADDR_EVENT)) begin
                            st_d.rdata = {29'h0000_0000, st_q.edge_odd,
                                          st_q.ss_sync[1], st_q.sck_lvl};
                        end
                    end
                end
            end
            SPC_BUS_ANSWER: begin
                st_d.bus = SPC_BUS_IDLE;
                if (avs_write && avs_byteenable[0]) begin
                    if (hit(avs_address, `SPC_ADDR_CONTROL)) begin
                        st_d.ctrl = avs_writedata[7:0];
                    end else if (hit(avs_address, `SPC_ADDR_STATUS)) begin
                        // write one to clear; a same-cycle event still sets
                        if (avs_writedata[`SPC_BIT_EOT] && !end_of_transfer_in) begin
                            st_d.end_of_transfer_flag = 1'b0;
                        end
                        if (avs_writedata[`SPC_BIT_MODE_FAULT_FLAG]) begin
                            st_d.mode_fault_flag = 1'b0;
                        end
                        if (avs_writedata[`SPC_BIT_OVR] && !overrun_in) begin
                            st_d.overrun_flag = 1'b0;
                        end
                    end
                end
            end
            default: st_d.bus = SPC_BUS_IDLE;
        endcase
        st_d.waitreq = (st_d.bus != SPC_BUS_ANSWER);

        // mode fault after any software write, so hardware clear wins
        if (st_d.ctrl[`SPC_BIT_MASTER] && !st_q.ss_sync[1]) begin
            st_d.ctrl[`SPC_BIT_PORT_EN] = 1'b0;
            st_d.ctrl[`SPC_BIT_MASTER]  = 1'b0;
            st_d.mode_fault_flag        = 1'b1;
        end

        master_now = st_q.ctrl[`SPC_BIT_MASTER];
        cpol_now   = st_q.ctrl[`SPC_BIT_CPOL];

        // sck level: generated as master, followed as slave
        if (!st_q.ctrl[`SPC_BIT_PORT_EN] || !xfer_busy_in) begin
            st_d.sck_lvl  = cpol_now;
            st_d.edge_odd = 1'b0;
        end else if (master_now) begin
            if (tick) begin
                st_d.sck_lvl = !st_q.sck_lvl;
                sck_edge     = 1'b1;
            end
        end else begin
            // slave rate is set by the peer, rate bits ignored
            st_d.sck_lvl = st_q.sck_sync[1];
            sck_edge     = st_q.sck_sync[1] != st_q.sck_prev;
        end
        if (sck_edge) begin
            st_d.edge_odd = !st_q.edge_odd;
            // capture on odd edges for phase 0, even edges for phase 1
            st_d.sample = st_q.ctrl[`SPC_BIT_CPHA] ? st_q.edge_odd : !st_q.edge_odd;
        end

        st_d.irq = st_q.ctrl[`SPC_BIT_IRQ_EN] && (st_q.end_of_transfer_flag
                   || st_q.mode_fault_flag || st_q.overrun_flag);
        st_d.pins    = st_q.ctrl[`SPC_BIT_PORT_EN];
        st_d.sck_oe  = st_q.ctrl[`SPC_BIT_PORT_EN] && master_now;
        st_d.mosi_oe = st_q.ctrl[`SPC_BIT_PORT_EN] && master_now;
        st_d.miso_oe = st_q.ctrl[`SPC_BIT_PORT_EN] && !master_now
                       && !st_q.ss_sync[1];
        st_d.master  = master_now;
        st_d.cpha    = st_q.ctrl[`SPC_BIT_CPHA];
        st_d.cpol    = cpol_now;
        st_d.sck_drv = master_now ? st_d.sck_lvl : cpol_now;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q      <= '0;
            st_q.bus  <= SPC_BUS_IDLE;
            // lower nibble has no defined reset; zero avoids x in simulation
            st_q.ctrl <= {`SPC_CTRL_UPPER_RST, `SPC_CTRL_LOWER_INIT};
            st_q.ss_sync <= 2'b11;
            st_q.waitreq <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign avs_readdata     = st_q.rdata;
    assign avs_waitrequest  = st_q.waitreq;
    assign sck_out          = st_q.sck_drv;
    assign sck_oe_out       = st_q.sck_oe;
    assign mosi_oe_out      = st_q.mosi_oe;
    assign miso_oe_out      = st_q.miso_oe;
    assign pins_to_port_out = st_q.pins;
    assign cpha_out         = st_q.cpha;
    assign cpol_out         = st_q.cpol;
    assign master_out       = st_q.master;
    assign sample_edge_out  = st_q.sample;
    assign irq_out          = st_q.irq;
endmodule // spc_control

/* File: tb/spc_props.sv */
module spc_props (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic end_of_transfer_in,
    input wire logic overrun_in,
    input wire logic xfer_busy_in,
    input wire logic ss_n_in,
    input wire logic sck_out,
    input wire logic sck_oe_out,
    input wire logic mosi_oe_out,
    input wire logic miso_oe_out,
    input wire logic pins_to_port_out,
    input wire logic cpol_out,
    input wire logic master_out,
    input wire logic irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [3:0] quiet_q;
    // cycles since anything that may legally raise the interrupt
    always_ff @(posedge clk_in) begin
        if (rst_in || avs_write || end_of_transfer_in || overrun_in || !ss_n_in) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hF) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    sck_drive_a: assert property (sck_oe_out == (master_out && pins_to_port_out))
        else $error("sck drive does not match enabled master");
    mosi_drive_a: assert property (mosi_oe_out == (master_out && pins_to_port_out))
        else $error("mosi drive does not match enabled master");
    miso_drive_a: assert property (miso_oe_out |-> pins_to_port_out && !master_out)
        else $error("miso driven outside enabled slave");
    sck_idle_a: assert property ((master_out && !xfer_busy_in && $stable(cpol_out))[*3]
        |-> sck_out == cpol_out) else $error("sck idle level differs from polarity");
    mode_fault_a: assert property (master_out && pins_to_port_out && !ss_n_in
        |-> ##[1:4] (!master_out && !pins_to_port_out)) else $error("mode fault not taken");
    irq_cause_a: assert property ($rose(irq_out) |-> quiet_q < 4'h6)
        else $error("interrupt rose without a cause");
    cover property (avs_write && !avs_waitrequest);
    cover property (master_out && !ss_n_in);
    cover property ($rose(irq_out));
endmodule // spc_props

bind spc_control spc_props u_props (.clk_in, .rst_in, .avs_read, .avs_write, .avs_waitrequest,
    .end_of_transfer_in, .overrun_in, .xfer_busy_in, .ss_n_in, .sck_out, .sck_oe_out,
    .mosi_oe_out, .miso_oe_out, .pins_to_port_out, .cpol_out, .master_out, .irq_out);

/* File: tb/spc_peer.sv */
module spc_peer (
    input  wire logic       clk_in,
    input  wire logic       sel_in,
    input  wire logic       cpol_in,
    input  wire logic [3:0] edges_in,
    output logic            ss_n_out,
    output logic            sck_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] done_q;
    logic [1:0] div_q;
    // select line is pulled up when released
    assign ss_n_out = !sel_in;
    always_ff @(posedge clk_in) begin
        if (!sel_in) begin
            div_q   <= 2'h0;
            done_q  <= 4'h0;
            sck_out <= cpol_in; // same idle level as the device
        end else begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3 && done_q != edges_in) begin
                done_q  <= done_q + 4'h1;
                sck_out <= !sck_out;
            end
        end
    end
endmodule // spc_peer

/* File: tb/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'b0, rst_in = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic        end_of_transfer_in = 1'b0, overrun_in = 1'b0, xfer_busy_in = 1'b0;
    logic        peer_sel = 1'b0, peer_cpol = 1'b0, ss_n_in, sck_in, avs_waitrequest;
    logic        sck_out, sck_oe_out, mosi_oe_out, miso_oe_out, pins_to_port_out;
    logic        cpha_out, cpol_out, master_out, sample_edge_out, irq_out;
    logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hF, peer_edges = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    int          fail_count = 0, tests_run = 0, edge_cnt = 0;
    always #10 clk_in = !clk_in;
    always @(posedge clk_in) if (sample_edge_out === 1'b1) edge_cnt <= edge_cnt + 1;
    spc_control uut (.clk_in, .rst_in, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .end_of_transfer_in, .overrun_in,
        .xfer_busy_in, .ss_n_in, .sck_in, .sck_out, .sck_oe_out, .mosi_oe_out, .miso_oe_out,
        .pins_to_port_out, .cpha_out, .cpol_out, .master_out, .sample_edge_out, .irq_out);
    spc_peer peer (.clk_in, .sel_in(peer_sel), .cpol_in(peer_cpol), .edges_in(peer_edges),
        .ss_n_out(ss_n_in), .sck_out(sck_in));
    task automatic end_sim();
        if (fail_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            end_sim();
        end
    endtask
    task automatic t_reset();
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h0);
        chk(pins_to_port_out, 1'b0);
        bus(1'b0, 4'hC, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic t_rate();
        logic [2:0] code [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
        logic [31:0] c;
        logic s;
        int n;
        for (int i = 0; i < 6; i++) begin
            c = {24'h0, 2'b00, code[i][2], 1'b1, i[0], 1'b0, code[i][1:0]};
            bus(1'b1, 4'h0, c); // port already off here
            repeat (3) @(posedge clk_in);
            chk(sck_out, i[0]);
            chk(cpol_out, i[0]);
            bus(1'b1, 4'h0, c | 32'h40);
            xfer_busy_in <= 1'b1;
            for (int k = 0; k < 2; k++) begin
                n = 0;
                s = sck_out;
                while (sck_out === s && n < 300) begin
                    @(posedge clk_in);
                    n++;
                end
            end
            chk(n, 2 << i); // half period in cpu clocks
            chk(sck_oe_out, 1'b1);
            bus(1'b1, 4'h0, c); // port off before polarity change
            xfer_busy_in <= 1'b0;
        end
    endtask
    task automatic t_fault();
        bus(1'b1, 4'h0, 32'hD0);
        peer_sel <= 1'b1;
        repeat (6) @(posedge clk_in);
        peer_sel <= 1'b0;
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h80);
        chk(master_out, 1'b0);
        chk(pins_to_port_out, 1'b0);
        bus(1'b0, 4'h4, 32'h0);
        chk(rd, 32'h2);
        chk(irq_out, 1'b1);
        bus(1'b1, 4'h4, 32'h2);
        repeat (2) @(posedge clk_in);
        chk(irq_out, 1'b0);
    endtask
    task automatic t_events();
        bus(1'b1, 4'h0, 32'h0);
        end_of_transfer_in <= 1'b1;
        @(posedge clk_in);
        end_of_transfer_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        chk(irq_out, 1'b0);
        bus(1'b1, 4'h0, 32'h80);
        repeat (2) @(posedge clk_in);
        chk(irq_out, 1'b1);
        bus(1'b1, 4'h4, 32'h1);
        overrun_in <= 1'b1;
        @(posedge clk_in);
        overrun_in <= 1'b0;
        bus(1'b0, 4'h4, 32'h0);
        chk(rd, 32'h4);
        chk(irq_out, 1'b1);
        bus(1'b1, 4'h4, 32'h4);
    endtask
    // one peer clock edge: captured only when phase is zero
    task automatic t_slave();
        int base;
        for (int c = 0; c < 2; c++) begin
            bus(1'b1, 4'h0, 32'h40 | (c << 2));
            xfer_busy_in <= 1'b1;
            peer_edges <= 4'h1;
            base = edge_cnt;
            peer_sel <= 1'b1; // peer keeps the same polarity
            repeat (20) @(posedge clk_in);
            chk(miso_oe_out, 1'b1);
            chk(cpha_out, c[0]);
            chk(edge_cnt - base, (c == 0) ? 1 : 0);
            bus(1'b0, 4'h8, 32'h0);
            chk(rd, 32'h5);
            xfer_busy_in <= 1'b0;
            @(posedge clk_in);
            peer_sel <= 1'b0;
            // synchronised sck must settle before the next frame
            repeat (4) @(posedge clk_in);
        end
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_rate();
        t_fault();
        t_events();
        t_slave();
        end_sim();
    end
endmodule // tb_top
